//--- g711_defs.svh
// Register map, field positions and constants of the companding unit
`ifndef G711_DEFS_SVH
`define G711_DEFS_SVH

// Register indices; byte address is four times the index
`define FMT_IDX 4
`define CTRL_IDX 5
`define STAT_IDX 6
`define IDX_TO_ADDR(i) (8'((i) * 4))

// Field positions
`define ADC_ALAW_BIT 1
`define ADC_EN_BIT 2
`define DAC_ALAW_BIT 3
`define DAC_EN_BIT 4
`define FORCE8_BIT 5
`define WORD_LEN_HI 6
`define WORD_LEN_LO 5
`define STAT_FILL_LSB 8

// Reset values and writable masks
`define CTRL_RST 8'h00
`define FMT_RST 8'h00
`define CTRL_MASK 8'h3e
`define FMT_MASK 8'h60

// Serial word lengths in bits
`define WORD_LEN_FORCED 6'd8
`define WORD_LEN_16 6'd16
`define WORD_LEN_20 6'd20
`define WORD_LEN_24 6'd24
`define WORD_LEN_32 6'd32

// Codec constants and FIFO depth
`define MU_BIAS 14'h0021
`define MU_CLIP 14'h1fde
`define MU_DBIAS 16'h0084
`define A_XOR 8'h55
`define FIFO_DEPTH 16

// Bus responses
`define RESP_OK 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- g711_pkg.sv
// Types shared by the companding unit
package g711_pkg;
	typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_e;
	typedef logic [5:0] word_len_t;
endpackage : g711_pkg

//--- g711_companding_unit.sv
// Companding unit: register slave, sample FIFO, serial link and G.711 codec
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "g711_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
	parameter int W = 16,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(DEPTH):0] fill
);
	// Pointers wrap naturally, so DEPTH must be a power of two
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];
	assign fill = cnt_r;

	// Pointer and count update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage needs no reset; empty words are never read out
	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////
module g711_companding_unit
	import g711_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [15:0] adc_data,
	input wire logic adc_valid,
	output logic adc_ready,
	output logic [15:0] dac_data,
	output logic dac_valid,
	input wire logic bclk,
	input wire logic fsync,
	input wire logic rx_sd,
	output logic tx_sd
);
	// mu-law: 14-bit signed input, clip, bias, find segment
	function automatic logic [7:0] mu_enc(input logic [15:0] x);
		logic [13:0] m;
		logic [2:0] seg;
		m = x[15] ? 14'(~x[15:2] + 14'd1) : x[15:2];
		if (m > `MU_CLIP) m = `MU_CLIP;
		m = m + `MU_BIAS;
		seg = 3'd0;
		for (int i = 1; i < 8; i++) if (m[i+5]) seg = 3'(i);
		return ~{x[15], seg, 4'(m >> ({1'b0, seg} + 4'd1))};
	endfunction : mu_enc

	function automatic logic [15:0] mu_dec(input logic [7:0] c);
		logic [7:0] d;
		logic [15:0] v;
		d = ~c;
		v = (16'({d[3:0], 3'b000}) + `MU_DBIAS) << d[6:4];
		v = v - `MU_DBIAS;
		return d[7] ? -v : v;
	endfunction : mu_dec

	// A-law: 13-bit signed input, 12-bit magnitude, even bits inverted
	function automatic logic [7:0] a_enc(input logic [15:0] x);
		logic [11:0] m;
		logic [2:0] seg;
		logic [3:0] man;
		m = x[15] ? ~x[14:3] : x[14:3];
		seg = 3'd0;
		for (int i = 1; i < 8; i++) if (m[i+4]) seg = 3'(i);
		man = (seg == 3'd0) ? m[4:1] : 4'(m >> seg);
		return {~x[15], seg, man} ^ `A_XOR;
	endfunction : a_enc

	function automatic logic [15:0] a_dec(input logic [7:0] c);
		logic [7:0] d;
		logic [7:0] t;
		logic [15:0] v;
		d = c ^ `A_XOR;
		t = {d[3:0], 4'h8};
		v = (d[6:4] == 3'd0) ? 16'(t) : 16'({1'b1, t}) << (d[6:4] - 3'd1);
		return d[7] ? v : -v;
	endfunction : a_dec

	////////////////////////////////////////////////////////////////////////
	// Register slave state
	logic [7:0] ctrl_r, ctrl_nxt, fmt_r, fmt_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0] waddr_r, waddr_nxt, wbyte_r, wbyte_nxt;
	logic wstb_r, wstb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	word_len_t word_len;
	logic [4:0] fill;

	assign awready = !aw_got_r && !bvalid_r;
	assign wready = !w_got_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// Forced 8-bit mode masks the programmed word length
	always_comb begin
		if (ctrl_r[`FORCE8_BIT]) begin
			word_len = `WORD_LEN_FORCED;
		end else begin
			case (fmt_r[`WORD_LEN_HI:`WORD_LEN_LO])
				2'b00: word_len = `WORD_LEN_16;
				2'b01: word_len = `WORD_LEN_20;
				2'b10: word_len = `WORD_LEN_24;
				default: word_len = `WORD_LEN_32;
			endcase
		end
	end

	// Address and data are taken in either order; response after both
	always_comb begin
		ctrl_nxt = ctrl_r;
		fmt_nxt = fmt_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wbyte_nxt = wbyte_r;
		wstb_nxt = wstb_r;
		bvalid_nxt = bvalid_r && !bready;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r && !rready;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (awvalid && awready) begin
			aw_got_nxt = 1'b1;
			waddr_nxt = awaddr;
		end
		if (wvalid && wready) begin
			w_got_nxt = 1'b1;
			wbyte_nxt = wdata[7:0];
			wstb_nxt = wstrb[0];
		end
		if (aw_got_r && w_got_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = `RESP_OK;
			if (waddr_r == `IDX_TO_ADDR(`CTRL_IDX)) begin
				if (wstb_r) ctrl_nxt = wbyte_r & `CTRL_MASK;
			end else if (waddr_r == `IDX_TO_ADDR(`FMT_IDX)) begin
				if (wstb_r) fmt_nxt = wbyte_r & `FMT_MASK;
			end else if (waddr_r != `IDX_TO_ADDR(`STAT_IDX)) begin
				bresp_nxt = `RESP_SLVERR;
			end
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `RESP_OK;
			case (araddr)
				`IDX_TO_ADDR(`CTRL_IDX): rdata_nxt = {24'h0, ctrl_r};
				`IDX_TO_ADDR(`FMT_IDX): rdata_nxt = {24'h0, fmt_r};
				`IDX_TO_ADDR(`STAT_IDX): rdata_nxt = 32'(word_len) | (32'(fill) << `STAT_FILL_LSB);
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = `RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `CTRL_RST;
			fmt_r <= `FMT_RST;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 8'h00;
			wbyte_r <= 8'h00;
			wstb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OK;
			rvalid_r <= 1'b0;
			rresp_r <= `RESP_OK;
			rdata_r <= 32'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			fmt_r <= fmt_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wbyte_r <= wbyte_nxt;
			wstb_r <= wstb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit side: compress on entry so the FIFO holds ready-to-send words
	logic [7:0] enc;
	logic [15:0] fifo_in, fifo_out;
	logic fifo_valid, pop;

	assign enc = ctrl_r[`ADC_ALAW_BIT] ? a_enc(adc_data) : mu_enc(adc_data);
	assign fifo_in = ctrl_r[`ADC_EN_BIT] ? {enc, 8'h00} : adc_data;

	word_fifo #(.W(16), .DEPTH(`FIFO_DEPTH)) tx_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(adc_valid),
		.in_ready(adc_ready),
		.in_data(fifo_in),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_out),
		.fill(fill)
	);

	////////////////////////////////////////////////////////////////////////
	// Link pins cross in through two flops; third bclk flop only feeds edge finding, third fsync flop feeds nothing
	logic [2:0] bclk_r, fs_r;
	logic [1:0] sd_r;
	logic bclk_rise, bclk_fall;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bclk_r <= 3'h0;
			fs_r <= 3'h0;
			sd_r <= 2'h0;
		end else begin
			bclk_r <= {bclk_r[1:0], bclk};
			fs_r <= {fs_r[1:0], fsync};
			sd_r <= {sd_r[0], rx_sd};
		end
	end

	assign bclk_rise = bclk_r[1] && !bclk_r[2];
	assign bclk_fall = !bclk_r[1] && bclk_r[2];

	// Serial framing state
	link_state_e state_r, state_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [31:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt, rx_word, rx_align;
	logic fs_seen_r, fs_seen_nxt, tx_sd_r, tx_sd_nxt;
	logic [15:0] dac_data_r, dac_data_nxt;
	logic dac_valid_r, dac_valid_nxt;
	logic word_end;

	assign rx_word = {rx_sh_r[30:0], sd_r[1]};
	assign rx_align = rx_word << (`WORD_LEN_32 - word_len);
	assign word_end = state_r == LINK_SHIFT && bclk_rise && cnt_r == word_len - 6'd1;
	assign tx_sd = tx_sd_r;
	assign dac_data = dac_data_r;
	assign dac_valid = dac_valid_r;

	// Frame starts on the first bclk rise that sees fsync high
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		rx_sh_nxt = rx_sh_r;
		tx_sh_nxt = tx_sh_r;
		tx_sd_nxt = tx_sd_r;
		fs_seen_nxt = fs_seen_r;
		dac_data_nxt = dac_data_r;
		dac_valid_nxt = 1'b0;
		pop = 1'b0;
		// Output lags one half bit so the host samples a settled level
		if (bclk_fall) begin
			tx_sd_nxt = tx_sh_r[31];
			tx_sh_nxt = {tx_sh_r[30:0], 1'b0};
		end
		if (bclk_rise) fs_seen_nxt = fs_r[1];
		case (state_r)
			LINK_IDLE: begin
				if (bclk_rise && fs_r[1] && !fs_seen_r) begin
					state_nxt = LINK_SHIFT;
					cnt_nxt = 6'd1;
					rx_sh_nxt = {31'h0, sd_r[1]};
					// An empty FIFO sends an all-zero word rather than stalling the link
					tx_sh_nxt = fifo_valid ? {fifo_out, 16'h0} : 32'h0;
					pop = fifo_valid;
				end
			end
			LINK_SHIFT: begin
				if (bclk_rise) begin
					rx_sh_nxt = rx_word;
					cnt_nxt = cnt_r + 6'd1;
				end
				if (word_end) begin
					state_nxt = LINK_IDLE;
					dac_valid_nxt = 1'b1;
					if (ctrl_r[`DAC_EN_BIT]) begin
						dac_data_nxt = ctrl_r[`DAC_ALAW_BIT] ? a_dec(rx_align[31:24])
							: mu_dec(rx_align[31:24]);
					end else begin
						dac_data_nxt = rx_align[31:16];
					end
				end
			end
			default: state_nxt = LINK_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= LINK_IDLE;
			cnt_r <= 6'd0;
			rx_sh_r <= 32'h0;
			tx_sh_r <= 32'h0;
			tx_sd_r <= 1'b0;
			fs_seen_r <= 1'b0;
			dac_data_r <= 16'h0;
			dac_valid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			rx_sh_r <= rx_sh_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_sd_r <= tx_sd_nxt;
			fs_seen_r <= fs_seen_nxt;
			dac_data_r <= dac_data_nxt;
			dac_valid_r <= dac_valid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence adc_mu_s;
		adc_valid && ctrl_r[`ADC_EN_BIT] && !ctrl_r[`ADC_ALAW_BIT];
	endsequence
	sequence adc_a_s;
		adc_valid && ctrl_r[`ADC_EN_BIT] && ctrl_r[`ADC_ALAW_BIT];
	endsequence
	sequence dac_a_end_s;
		word_end && ctrl_r[`DAC_EN_BIT] && ctrl_r[`DAC_ALAW_BIT];
	endsequence

	force8_len_a: assert property (ctrl_r[`FORCE8_BIT] |-> word_len == 6'd8)
		else $error("forced mode word length not eight");
	len_ignored_a: assert property (ctrl_r[`FORCE8_BIT] && $stable(ctrl_r) && $changed(fmt_r)
		|-> word_len == $past(word_len)) else $error("word length followed format in 8-bit mode");
	adc_bypass_a: assert property (adc_valid && !ctrl_r[`ADC_EN_BIT] |-> fifo_in == adc_data)
		else $error("linear sample altered with companding off");
	mu_zero_a: assert property (adc_mu_s and adc_data == 16'h0 |-> fifo_in[15:8] == 8'hff)
		else $error("mu-law zero code wrong");
	a_zero_a: assert property (adc_a_s and adc_data == 16'h0 |-> fifo_in[15:8] == 8'hd5)
		else $error("A-law zero code wrong");
	mu_peak_a: assert property (adc_mu_s and adc_data == 16'h7fff |-> fifo_in[15:8] == 8'h80)
		else $error("mu-law peak code wrong");
	code_shape_a: assert property (adc_valid && ctrl_r[`ADC_EN_BIT] |-> fifo_in[7:0] == 8'h00)
		else $error("companded word wider than eight bits");
	reset_off_a: assert property ($rose(aresetn) |-> ctrl_r[4:1] == 4'h0)
		else $error("companding active after reset");
	rx_to_dac_a: assert property (word_end |=> dac_valid ##1 !dac_valid)
		else $error("received word not handed to DAC path once");
	dac_alaw_a: assert property (dac_a_end_s |=> dac_data == a_dec($past(rx_align[31:24])))
		else $error("A-law expansion wrong");
endmodule : g711_companding_unit

//--- link_host.sv
// Host end of the serial link: bit clock, frame sync and both data lines
`timescale 1ns/1ns

module link_host (
	input wire logic aclk,
	output logic bclk,
	output logic fsync,
	output logic rx_sd,
	input wire logic tx_sd
);
	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
		rx_sd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Half a bit period is eight fabric cycles, so 64 ns per bit
	task half;
		repeat (8) @(posedge aclk);
	endtask : half

	// One frame of n bits; bclk stands low between frames
	task frame(input logic [31:0] send_w, input int n, output logic [31:0] got_w);
		got_w = '0;
		half();
		bclk <= 1'b1; // Lead rise with fsync low arms the next start
		half();
		bclk <= 1'b0;
		for (int i = 0; i <= n; i++) begin
			fsync <= (i == 0);
			// Released line shows the inverse of its last bit
			rx_sd <= (i < n) ? send_w[31-i] : ~send_w[32-n];
			half();
			bclk <= 1'b1;
			if (i > 0) got_w[32-i] = tx_sd;
			half();
			bclk <= 1'b0;
		end
	endtask : frame
endmodule : link_host

//--- testbench.sv
// Self-checking bench: register bus, sample stream and serial link
`timescale 1ns/1ns

module testbench;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, adc_valid, adc_ready, dac_valid;
	logic bclk, fsync, rx_sd, tx_sd;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, word;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] adc_data, dac_data, dac_last;
	logic [15:0] samp[3] = '{16'h0000, 16'h7fff, 16'h8000};
	logic [7:0] code[2][3] = '{'{8'hff, 8'h80, 8'h00}, '{8'hd5, 8'haa, 8'h2a}};
	// Linear values of the standard expansion curves, per law: zero, +max, -max codes
	logic [15:0] lin[2][3] = '{'{16'h0000, 16'h7d7c, 16'h8284}, '{16'h0008, 16'h7e00, 16'h8200}};
	int num_errors = 0, tests_run = 0, cycles = 0, dac_count = 0;

	g711_companding_unit DUT (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready),
		.dac_data(dac_data), .dac_valid(dac_valid),
		.bclk(bclk), .fsync(fsync), .rx_sd(rx_sd), .tx_sd(tx_sd)
	);
	link_host host (.aclk(aclk), .bclk(bclk), .fsync(fsync), .rx_sd(rx_sd), .tx_sd(tx_sd));

	always #2 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog, and capture of every expanded sample
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (dac_valid === 1'b1) begin
			dac_last <= dac_data;
			dac_count <= dac_count + 1;
		end
		if (cycles == 60000) begin
			num_errors = num_errors + 1;
			close_out();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] want, input string what);
		tests_run++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask : check

	// Each task that drives a signal first lets an edge pass, so none is driven twice in a step
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !aw_done) awvalid <= 1'b0;
			if (wready === 1'b1 && !w_done) wvalid <= 1'b0;
			aw_done = aw_done || (awready === 1'b1);
			w_done = w_done || (wready === 1'b1);
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task rchk(input logic [7:0] a, input logic [31:0] want, input string what);
		rd(a, word, resp);
		check(word, want, what);
	endtask : rchk

	task push(input logic [15:0] s);
		@(posedge aclk);
		adc_data <= s;
		adc_valid <= 1'b1;
		do @(posedge aclk); while (adc_ready !== 1'b1);
		adc_valid <= 1'b0;
	endtask : push

	task link(input logic [31:0] send, input int n, input logic [31:0] want, input string what);
		host.frame(send, n, word);
		check(word, want, what);
	endtask : link

	task close_out;
		$display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, adc_valid} = '0;
		{awaddr, araddr, wdata, adc_data} = '0;
		wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, unmapped place, forced length over the format field
		rchk(8'h14, 32'h0, "control reset");
		rchk(8'h18, 32'h10, "status reset");
		rd(8'h40, word, resp);
		check(resp, 2'b10, "unmapped read");
		wr(8'h10, 32'h60);
		rchk(8'h18, 32'h20, "length 32");
		wr(8'h14, 32'h20);
		check(resp, 2'b00, "write okay");
		rchk(8'h18, 32'h8, "forced length");
		wr(8'h10, 32'h20);
		rchk(8'h18, 32'h8, "format ignored");
		rchk(8'h10, 32'h20, "format kept");
		wr(8'h40, 32'h3e);
		check(resp, 2'b10, "unmapped write");
		rchk(8'h14, 32'h20, "control untouched");
		$display("test registers done");
		// Fill the queue until refused, then drain it over the link
		for (int i = 0; i < 16; i++) push({8'(8'h11 * i), 8'h00});
		@(posedge aclk);
		check(adc_ready, 1'b0, "full refuses");
		rchk(8'h18, 32'h1008, "fill 16");
		for (int i = 0; i < 16; i++) link(32'h0, 8, {8'(8'h11 * i), 24'h0}, "drain");
		link(32'h0, 8, 32'h0, "empty sends zero");
		rchk(8'h18, 32'h8, "fill 0");
		check(dac_count, 17, "one word per frame");
		$display("test buffer done");
		// Compression for both laws on the transmit side
		for (int law = 0; law < 2; law++) begin
			wr(8'h14, 32'h24 | (law << 1));
			for (int k = 0; k < 3; k++) push(samp[k]);
			for (int k = 0; k < 3; k++) link(32'h0, 8, {code[law][k], 24'h0}, "compress");
		end
		$display("test compress done");
		// Expansion for both laws on the receive side
		for (int law = 0; law < 2; law++) begin
			wr(8'h14, 32'h30 | (law << 3));
			link({code[law][1], 24'h0}, 8, 32'h0, "rx positive");
			check(dac_last[15], 1'b0, "positive sign");
			check(dac_last, lin[law][1], "positive value");
			link({code[law][2], 24'h0}, 8, 32'h0, "rx negative");
			check(dac_last[15], 1'b1, "negative sign");
			check(dac_last, lin[law][2], "negative value");
		end
		// Companding without the forced length: the code is the first 8 of 20 bits
		wr(8'h14, 32'h10);
		rchk(8'h18, 32'h14, "length 20");
		link(32'hff00_0000, 20, 32'h0, "rx mu zero");
		check(dac_last, 16'h0, "mu zero expands to zero");
		$display("test expand done");
		// Plain 16-bit words pass through when companding is off
		wr(8'h14, 32'h0);
		wr(8'h10, 32'h0);
		push(16'hbeef);
		link(32'h1234_0000, 16, 32'hbeef_0000, "raw transmit");
		check(dac_last, 16'h1234, "raw receive");
		$display("test passthrough done");
		close_out();
	end
endmodule : testbench
